// file: inc/rss_consts.vh
/*
 * Constants of the supervisor and status block: register indices, field
 * positions, reset values and timing figures.
 * Assumes a 50 MHz system clock and word-aligned AXI4-Lite registers.
 */
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH

// register indices, byte address is four times the index
`define RSS_IDX_SECONDS   6'h01
`define RSS_IDX_HOURS     6'h04
`define RSS_IDX_DATE      6'h05
`define RSS_IDX_YEAR      6'h07
`define RSS_IDX_CONTROL   6'h08
`define RSS_IDX_FLAGS     6'h0f
`define RSS_IDX_CENTURY   6'h20
`define RSS_IDX_CFG_A     6'h21
`define RSS_IDX_CFG_B     6'h22
`define RSS_IDX_WDOG      6'h23
`define RSS_IDX_SERIAL_LO 6'h24
`define RSS_IDX_SERIAL_HI 6'h25
`define RSS_IDX_STATUS    6'h26

// field positions
`define RSS_BIT_HALT      7
`define RSS_BIT_DESEL_LEN 7
`define RSS_BIT_OUT       7
`define RSS_BIT_BAT_LOW   4
`define RSS_BIT_OSC_FAIL  2
`define RSS_BIT_WDOG_STEER 7

// initial power-up values
`define RSS_RST_CFG_A     8'he0
`define RSS_RST_CFG_B     8'h80
`define RSS_RST_WDOG      8'h00
`define RSS_RST_OUT       1'b1
`define RSS_RST_OSC_FAIL  1'b1

// timing
`define RSS_CLK_HZ        50000000
`define RSS_TREC_LONG_MS  96
`define RSS_TREC_HALT_MS  40
`define RSS_TREC_SHORT_US 50
`define RSS_BATT_CHECK_H  24

// axi responses
`define RSS_RESP_OKAY     2'b00
`define RSS_RESP_SLVERR   2'b10

`endif

// file: design/rss_top.v
/*
 * Supervisor and status logic of a serial real-time clock: power-fail
 * output drive, century bits and leap year, interrupt/output pin,
 * battery checks, deselect recovery time, serial number, oscillator-stop
 * flag and power-on defaults, behind an AXI4-Lite slave.
 * Assumes analog comparators, oscillator monitor and supply detector give
 * asynchronous levels; alarm, watchdog and tamper requests and the year
 * advance pulse come from logic on i_clk.
 */
// Operation
// - power-fail outputs open-drain or push-pull by select
// - century bits count above year register
// - century leap day only when century code zero
// - no source enabled: pin follows out bit
// - fallback low stays driven on backup if enabled
// - battery checked at power-up and daily
// - low flag held until a later check passes
// - battery checks only on main supply
// - deselect length bit in register 04h
// - recovery time chosen by length and halt bits
// - read-only eight-byte serial number
// - oscillator fail flag set whenever oscillator stops
// - enabled oscillator fail asserts interrupt pin
// - interrupt removed by flag, enable or reset
// - fail flag holds until software writes zero
// - detection on backup, pin held released until recovery ends
// - initial power-up loads documented defaults
// - supply edges clear their listed bits
// - tamper enable blocks halt flag at power-down
// - other control bits need software initialisation
// - power-on reset clears enables and watchdog, except the khz32 enable, which it sets
`timescale 1ns/1ns
`default_nettype none
`include "rss_consts.vh"

module rss_top #(
	parameter [31:0] TREC_LONG_CYC  = `RSS_TREC_LONG_MS * (`RSS_CLK_HZ / 1000),
	parameter [31:0] TREC_HALT_CYC  = `RSS_TREC_HALT_MS * (`RSS_CLK_HZ / 1000),
	parameter [47:0] BATT_CHECK_CYC = 48'd3600 * `RSS_BATT_CHECK_H
		* (`RSS_CLK_HZ),
	// serial value is arbitrary
	parameter [63:0] SERIAL_NUMBER  = 64'h0123_4567_89ab_cdef
) (
	input  wire        i_clk,
	input  wire        i_reset_n,
	input  wire [7:0]  i_axi_awaddr,
	input  wire        i_axi_awvalid,
	output reg         o_axi_awready,
	input  wire [31:0] i_axi_wdata,
	input  wire [3:0]  i_axi_wstrb,
	input  wire        i_axi_wvalid,
	output reg         o_axi_wready,
	output reg  [1:0]  o_axi_bresp,
	output reg         o_axi_bvalid,
	input  wire        i_axi_bready,
	input  wire [7:0]  i_axi_araddr,
	input  wire        i_axi_arvalid,
	output reg         o_axi_arready,
	output reg  [31:0] o_axi_rdata,
	output reg  [1:0]  o_axi_rresp,
	output reg         o_axi_rvalid,
	input  wire        i_axi_rready,
	input  wire        i_vcc_ok,
	input  wire        i_osc_running,
	input  wire        i_battery_low,
	input  wire        i_pfi1_low,
	input  wire        i_pfi2_low,
	input  wire        i_alarm_irq,
	input  wire        i_watchdog_irq,
	input  wire        i_tamper_irq,
	input  wire        i_year_advance,
	output reg         o_power_fail_output_1,
	output reg         o_power_fail_output_1_oe,
	output reg         o_power_fail_output_2,
	output reg         o_power_fail_output_2_oe,
	output reg         o_interrupt_level_pin,
	output reg         o_interrupt_level_pin_oe,
	output reg         o_reset_output_pin,
	output reg         o_reset_output_pin_oe,
	output reg         o_deselect,
	output reg         o_leap_year,
	output reg         o_khz32_output_enable,
	output reg         o_square_wave_enable
);

	localparam [31:0] TREC_SHORT_CYC = `RSS_TREC_SHORT_US
		* (`RSS_CLK_HZ / 1000000);

	// async pins: vcc, osc, battery, pfi1, pfi2
	reg  [4:0]  sync1_r;
	reg  [4:0]  sync2_r;
	wire        vcc    = sync2_r[0];
	wire        osc_ok = sync2_r[1];
	wire        bat_lo = sync2_r[2];

	reg         vcc_prev_r;
	reg  [31:0] trec_cnt_r;
	reg  [47:0] day_cnt_r;
	reg         halt_r;
	reg         desel_len_r;
	reg         out_r;
	reg  [7:0]  year_r;
	reg  [1:0]  century_r;
	reg         osc_fail_r;
	reg         bat_low_r;
	reg  [7:0]  cfg_a_r;
	reg  [7:0]  cfg_b_r;
	reg  [7:0]  wdog_r;

	// cfg_a fields
	wire osc_fail_irq_enable  = cfg_a_r[0];
	wire afe   = cfg_a_r[1];
	wire abe   = cfg_a_r[2];
	wire power_fail_drive_select  = cfg_a_r[5];
	// cfg_b fields
	wire [1:0] teb = cfg_b_r[2:1];
	wire [1:0] tamper_irq_enable = cfg_b_r[4:3];

	wire vcc_rise = vcc & ~vcc_prev_r;
	wire vcc_fall = ~vcc & vcc_prev_r;
	// the rise cycle counts too, else deselect blinks low before the load
	wire rst_act  = ~vcc | vcc_rise | (trec_cnt_r != 32'h0000_0000);

	// axi write path
	reg         aw_full_r;
	reg         w_full_r;
	reg  [7:0]  wr_addr_r;
	reg  [7:0]  wr_data_r;
	reg         wr_strb_r;
	wire [5:0]  wr_idx = wr_addr_r[7:2];
	wire        wr_go  = aw_full_r & w_full_r & ~o_axi_bvalid;
	wire        wr_en  = wr_go & wr_strb_r & mapped(wr_addr_r);

	function mapped;
		input [7:0] addr;
		begin
			mapped = (addr[1:0] == 2'b00) &&
				(addr[7:2] == `RSS_IDX_SECONDS ||
				addr[7:2] == `RSS_IDX_HOURS ||
				addr[7:2] == `RSS_IDX_DATE ||
				addr[7:2] == `RSS_IDX_YEAR ||
				addr[7:2] == `RSS_IDX_CONTROL ||
				addr[7:2] == `RSS_IDX_FLAGS ||
				(addr[7:2] >= `RSS_IDX_CENTURY &&
				addr[7:2] <= `RSS_IDX_STATUS));
		end
	endfunction

	// leap year from bcd year and century code
	reg  [6:0]  year_bin;
	reg         leap_nxt;
	always @*
	begin
		year_bin = {3'b000, year_r[7:4]} * 7'd10 + {3'b000, year_r[3:0]};
		if (year_r == 8'h00)
			leap_nxt = (century_r == 2'b00);
		else
			leap_nxt = (year_bin[1:0] == 2'b00);
	end

	// interrupt pin decision
	reg         any_en;
	reg         irq_src;
	reg         pin_low;
	always @*
	begin
		any_en = (|tamper_irq_enable) | osc_fail_irq_enable | afe |
			((wdog_r != 8'h00) & ~wdog_r[`RSS_BIT_WDOG_STEER]);
		irq_src = (osc_fail_r & osc_fail_irq_enable & ~rst_act) |
			(i_alarm_irq & afe) |
			(i_tamper_irq & (|tamper_irq_enable)) |
			(i_watchdog_irq & ~wdog_r[`RSS_BIT_WDOG_STEER] &
			(wdog_r != 8'h00));
		if (any_en)
			pin_low = irq_src;
		else
			pin_low = ~out_r;
	end

	// read mux
	reg  [7:0]  rd_byte;
	reg  [31:0] rd_word;
	always @*
	begin
		rd_byte = 8'h00;
		rd_word = 32'h0000_0000;
		case (i_axi_araddr[7:2])
		`RSS_IDX_SECONDS:   rd_byte = {halt_r, 7'h00};
		`RSS_IDX_HOURS:     rd_byte = {desel_len_r, 7'h00};
		`RSS_IDX_DATE:      rd_byte = {7'h00, o_leap_year};
		`RSS_IDX_YEAR:      rd_byte = year_r;
		`RSS_IDX_CONTROL:   rd_byte = {out_r, 7'h00};
		`RSS_IDX_FLAGS:     rd_byte = {3'b000, bat_low_r, 1'b0,
			osc_fail_r, 2'b00};
		`RSS_IDX_CENTURY:   rd_byte = {6'h00, century_r};
		`RSS_IDX_CFG_A:     rd_byte = cfg_a_r;
		`RSS_IDX_CFG_B:     rd_byte = cfg_b_r;
		`RSS_IDX_WDOG:      rd_byte = wdog_r;
		`RSS_IDX_SERIAL_LO: rd_word = SERIAL_NUMBER[31:0];
		`RSS_IDX_SERIAL_HI: rd_word = SERIAL_NUMBER[63:32];
		`RSS_IDX_STATUS:    rd_byte = {3'b000, ~vcc, o_leap_year,
			o_interrupt_level_pin_oe, rst_act, o_deselect};
		default:            rd_byte = 8'h00;
		endcase
		if (rd_word == 32'h0000_0000)
			rd_word = {24'h00_0000, rd_byte};
	end

	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			sync1_r <= 5'h00;
			sync2_r <= 5'h00;
		end
		else
		begin
			sync1_r <= {i_pfi2_low, i_pfi1_low, i_battery_low,
				i_osc_running, i_vcc_ok};
			sync2_r <= sync1_r;
		end
	end

	// axi handshakes
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_axi_awready <= 1'b1;
			o_axi_wready  <= 1'b1;
			o_axi_bvalid  <= 1'b0;
			o_axi_bresp   <= `RSS_RESP_OKAY;
			o_axi_arready <= 1'b1;
			o_axi_rvalid  <= 1'b0;
			o_axi_rdata   <= 32'h0000_0000;
			o_axi_rresp   <= `RSS_RESP_OKAY;
			aw_full_r     <= 1'b0;
			w_full_r      <= 1'b0;
			wr_addr_r     <= 8'h00;
			wr_data_r     <= 8'h00;
			wr_strb_r     <= 1'b0;
		end
		else
		begin
			if (o_axi_awready && i_axi_awvalid)
			begin
				wr_addr_r     <= i_axi_awaddr;
				aw_full_r     <= 1'b1;
				o_axi_awready <= 1'b0;
			end
			if (o_axi_wready && i_axi_wvalid)
			begin
				wr_data_r    <= i_axi_wdata[7:0];
				wr_strb_r    <= i_axi_wstrb[0];
				w_full_r     <= 1'b1;
				o_axi_wready <= 1'b0;
			end
			if (wr_go)
			begin
				o_axi_bvalid <= 1'b1;
				o_axi_bresp  <= mapped(wr_addr_r) ? `RSS_RESP_OKAY
					: `RSS_RESP_SLVERR;
			end
			if (o_axi_bvalid && i_axi_bready)
			begin
				o_axi_bvalid  <= 1'b0;
				aw_full_r     <= 1'b0;
				w_full_r      <= 1'b0;
				o_axi_awready <= 1'b1;
				o_axi_wready  <= 1'b1;
			end
			if (o_axi_arready && i_axi_arvalid)
			begin
				o_axi_arready <= 1'b0;
				o_axi_rvalid  <= 1'b1;
				o_axi_rdata   <= mapped(i_axi_araddr) ? rd_word
					: 32'h0000_0000;
				o_axi_rresp   <= mapped(i_axi_araddr) ? `RSS_RESP_OKAY
					: `RSS_RESP_SLVERR;
			end
			if (o_axi_rvalid && i_axi_rready)
			begin
				o_axi_rvalid  <= 1'b0;
				o_axi_arready <= 1'b1;
			end
		end
	end

	// supply sequencing, recovery timer and battery checks
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			vcc_prev_r <= 1'b0;
			trec_cnt_r <= 32'h0000_0000;
			day_cnt_r  <= 48'h0000_0000_0000;
			bat_low_r  <= 1'b0;
		end
		else
		begin
			vcc_prev_r <= vcc;
			if (!vcc)
				trec_cnt_r <= 32'h0000_0000;
			else if (vcc_rise)
			begin
				if (desel_len_r)
					trec_cnt_r <= TREC_SHORT_CYC;
				else if (halt_r)
					trec_cnt_r <= TREC_HALT_CYC;
				else
					trec_cnt_r <= TREC_LONG_CYC;
			end
			else if (trec_cnt_r != 32'h0000_0000)
				trec_cnt_r <= trec_cnt_r - 32'h0000_0001;
			// the day count clears on backup, so checks never run there
			if (!vcc)
				day_cnt_r <= 48'h0000_0000_0000;
			else if (vcc_rise || day_cnt_r >= BATT_CHECK_CYC - 48'h1)
			begin
				day_cnt_r <= 48'h0000_0000_0000;
				bat_low_r <= bat_lo;
			end
			else
				day_cnt_r <= day_cnt_r + 48'h0000_0000_0001;
		end
	end

	// software-visible control state
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			halt_r      <= 1'b0;
			desel_len_r <= 1'b0;
			out_r       <= `RSS_RST_OUT;
			osc_fail_r  <= `RSS_RST_OSC_FAIL;
			cfg_a_r     <= `RSS_RST_CFG_A;
			cfg_b_r     <= `RSS_RST_CFG_B;
			wdog_r      <= `RSS_RST_WDOG;
			year_r      <= 8'h00;
			century_r   <= 2'b00;
		end
		else
		begin
			if (wr_en)
			begin
				case (wr_idx)
				`RSS_IDX_SECONDS: halt_r <= wr_data_r[`RSS_BIT_HALT];
				`RSS_IDX_HOURS:
					desel_len_r <= wr_data_r[`RSS_BIT_DESEL_LEN];
				`RSS_IDX_CONTROL: out_r <= wr_data_r[`RSS_BIT_OUT];
				`RSS_IDX_YEAR:    year_r <= wr_data_r;
				`RSS_IDX_CENTURY: century_r <= wr_data_r[1:0];
				`RSS_IDX_CFG_A:   cfg_a_r <= wr_data_r;
				`RSS_IDX_CFG_B:   cfg_b_r <= wr_data_r;
				`RSS_IDX_WDOG:    wdog_r <= wr_data_r;
				default:          ;
				endcase
			end
			else if (i_year_advance)
			begin
				if (year_r == 8'h99)
				begin
					year_r    <= 8'h00;
					century_r <= century_r + 2'b01;
				end
				else if (year_r[3:0] == 4'h9)
					year_r <= {year_r[7:4] + 4'h1, 4'h0};
				else
					year_r <= year_r + 8'h01;
			end
			// set beats a clearing write; on backup too
			if (~osc_ok | halt_r)
				osc_fail_r <= 1'b1;
			else if (wr_en && wr_idx == `RSS_IDX_FLAGS &&
				!wr_data_r[`RSS_BIT_OSC_FAIL])
				osc_fail_r <= 1'b0;
			// backup enable must survive the fall, so enables clear on rise
			if (vcc_rise)
			begin
				cfg_a_r[4:0] <= 5'h00;
				cfg_b_r[4:3] <= 2'b00;
				wdog_r       <= 8'h00;
			end
			else if (vcc_fall)
			begin
				cfg_a_r[4]   <= 1'b0;
				cfg_b_r[7]   <= ~(|teb);
				wdog_r       <= 8'h00;
			end
		end
	end

	// pins, all registered
	reg power_fail_output_1_lvl;
	reg power_fail_output_2_lvl;
	always @*
	begin
		power_fail_output_1_lvl = vcc & (rst_act | ~sync2_r[3]);
		power_fail_output_2_lvl = vcc & (rst_act | ~sync2_r[4]);
	end

	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_power_fail_output_1    <= 1'b0;
			o_power_fail_output_1_oe <= 1'b0;
			o_power_fail_output_2    <= 1'b0;
			o_power_fail_output_2_oe <= 1'b0;
			o_interrupt_level_pin    <= 1'b0;
			o_interrupt_level_pin_oe <= 1'b0;
			o_reset_output_pin       <= 1'b0;
			o_reset_output_pin_oe    <= 1'b1;
			o_deselect               <= 1'b1;
			o_leap_year              <= 1'b1;
			o_khz32_output_enable    <= 1'b0;
			o_square_wave_enable     <= 1'b0;
		end
		else
		begin
			// open drain drives only the low level
			o_power_fail_output_1    <= power_fail_drive_select ? 1'b0 : power_fail_output_1_lvl;
			o_power_fail_output_1_oe <= power_fail_drive_select ? ~power_fail_output_1_lvl : 1'b1;
			o_power_fail_output_2    <= power_fail_drive_select ? 1'b0 : power_fail_output_2_lvl;
			o_power_fail_output_2_oe <= power_fail_drive_select ? ~power_fail_output_2_lvl : 1'b1;
			o_interrupt_level_pin    <= 1'b0;
			o_interrupt_level_pin_oe <= pin_low & (vcc | abe);
			o_reset_output_pin       <= 1'b0;
			o_reset_output_pin_oe    <= rst_act;
			o_deselect               <= rst_act;
			o_leap_year              <= leap_nxt;
			o_khz32_output_enable    <= cfg_a_r[7] & ~halt_r & vcc;
			o_square_wave_enable     <= cfg_a_r[3];
		end
	end

endmodule

`default_nettype wire

// file: testbench/rss_pin_model.sv
/*
 * rss_pin_model: host side of the supervisor pins, with board pull-ups.
 * Assumes every pin arrives as a value and an enable from the block.
 */
`timescale 1ns/1ns
`default_nettype none
module rss_pin_model (
	input  wire logic i_power_fail_output_1,
	input  wire logic i_power_fail_output_1_oe,
	input  wire logic i_power_fail_output_2,
	input  wire logic i_power_fail_output_2_oe,
	input  wire logic i_irq,
	input  wire logic i_irq_oe,
	output var  logic o_power_fail_output_1_lvl,
	output var  logic o_power_fail_output_2_lvl,
	output var  logic o_irq_lvl_n
);
	// a released pin reads high through its pull-up, never the last value
	always_comb
	begin
		o_power_fail_output_1_lvl = i_power_fail_output_1_oe ? i_power_fail_output_1 : 1'b1;
		o_power_fail_output_2_lvl = i_power_fail_output_2_oe ? i_power_fail_output_2 : 1'b1;
		o_irq_lvl_n = i_irq_oe ? i_irq : 1'b1;
	end
endmodule
`default_nettype wire

// file: testbench/rss_sva_asserts.sv
/*
 * rss_sva: port checks for rss_top.
 * Assumes it is bound by name to rss_top with that module's counts.
 */
`timescale 1ns/1ns
`default_nettype none
module rss_sva #(
	parameter [31:0] TREC_LONG_CYC = 32'd4800000,
	parameter [31:0] TREC_HALT_CYC = 32'd2000000
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_vcc_ok,
	input wire logic i_alarm_irq,
	input wire logic i_watchdog_irq,
	input wire logic i_tamper_irq,
	input wire logic i_axi_awvalid,
	input wire logic i_axi_wvalid,
	input wire logic i_axi_arvalid,
	input wire logic o_axi_arready,
	input wire logic o_axi_bvalid,
	input wire logic o_power_fail_output_1,
	input wire logic o_power_fail_output_1_oe,
	input wire logic o_power_fail_output_2,
	input wire logic o_power_fail_output_2_oe,
	input wire logic o_interrupt_level_pin,
	input wire logic o_interrupt_level_pin_oe,
	input wire logic o_reset_output_pin_oe,
	input wire logic o_deselect
);
	// short recovery is a fixed count; halt count assumed below long
	localparam [31:0] SHORT = 32'd2500;
	localparam [31:0] MIN_CYC = (TREC_HALT_CYC < SHORT) ? TREC_HALT_CYC : SHORT;
	localparam [31:0] MAX_CYC = (TREC_LONG_CYC > SHORT) ? TREC_LONG_CYC : SHORT;
	logic [31:0] rec_cnt_r;

	always @(posedge i_clk or negedge i_reset_n)
		if (!i_reset_n)
			rec_cnt_r <= 32'h0;
		else if (!i_vcc_ok)
			rec_cnt_r <= 32'h0;
		else if (o_deselect)
			rec_cnt_r <= rec_cnt_r + 32'h1;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	a_pfo_one_mode:
	assert property (!o_power_fail_output_1_oe |-> !o_power_fail_output_2)
		else $error("power_fail_output_2 driven high while power_fail_output_1 released");
	a_pfo_mode_two:
	assert property (!o_power_fail_output_2_oe |-> !o_power_fail_output_1)
		else $error("power_fail_output_1 driven high while power_fail_output_2 released");
	a_pfo_push_pull:
	assert property (o_power_fail_output_1_oe && o_power_fail_output_1
		|-> o_power_fail_output_2_oe)
		else $error("pfo outputs in different drive modes");
	a_irq_sink_only:
	assert property (o_interrupt_level_pin_oe |-> !o_interrupt_level_pin)
		else $error("irq pin driven high");
	a_backup_blocks:
	assert property ($fell(i_vcc_ok) |-> ##[1:4] o_deselect)
		else $error("no deselect after supply loss");
	a_rec_min:
	assert property ($fell(o_deselect) |-> rec_cnt_r >= MIN_CYC)
		else $error("recovery time too short");
	a_rec_bounded:
	assert property (o_deselect && i_vcc_ok |-> rec_cnt_r <= MAX_CYC + 32'd8)
		else $error("recovery time too long");
	a_read_keeps_irq:
	assert property (i_axi_arvalid && o_axi_arready && o_interrupt_level_pin_oe
		&& !i_axi_awvalid && !i_axi_wvalid && !o_axi_bvalid
		&& !o_reset_output_pin_oe && !i_alarm_irq && !i_watchdog_irq
		&& !i_tamper_irq && i_vcc_ok && $past(i_vcc_ok, 3)
		|=> o_interrupt_level_pin_oe)
		else $error("irq released by a read");
endmodule
`default_nettype wire

// file: testbench/rss_testbench.sv
/*
 * testbench: directed scenarios for rss_top over its AXI4-Lite port.
 * Assumes long and halt recovery and battery counts set below; pins via model.
 */
`timescale 1ns/1ns
`default_nettype none
`include "rss_consts.vh"
module testbench;
	localparam [31:0] TL = 32'd200;
	localparam [31:0] TH = 32'd100;
	localparam [31:0] BC = 32'd1000;
	localparam [63:0] SER = 64'h5a5a_0f0f_1234_8765; // arbitrary value
	logic i_clk = 1'b0, i_reset_n = 1'b0;
	logic [7:0] i_axi_awaddr = 8'h0, i_axi_araddr = 8'h0;
	logic [31:0] i_axi_wdata = 32'h0;
	logic [3:0] i_axi_wstrb = 4'h1;
	logic i_axi_awvalid = 1'b0, i_axi_wvalid = 1'b0, i_axi_bready = 1'b0;
	logic i_axi_arvalid = 1'b0, i_axi_rready = 1'b0, i_vcc_ok = 1'b1;
	logic i_osc_running = 1'b1, i_battery_low = 1'b0, i_pfi1_low = 1'b0;
	logic i_pfi2_low = 1'b0, i_alarm_irq = 1'b0, i_watchdog_irq = 1'b0;
	logic i_tamper_irq = 1'b0, i_year_advance = 1'b0;
	wire o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready;
	wire o_axi_rvalid, o_deselect, o_leap_year, o_khz32_output_enable;
	wire [1:0] o_axi_bresp, o_axi_rresp;
	wire [31:0] o_axi_rdata;
	wire o_power_fail_output_1, o_power_fail_output_1_oe;
	wire o_power_fail_output_2, o_power_fail_output_2_oe;
	wire o_interrupt_level_pin, o_interrupt_level_pin_oe;
	wire o_reset_output_pin, o_reset_output_pin_oe, o_square_wave_enable;
	wire power_fail_output_1_lvl, power_fail_output_2_lvl, irq_lvl_n;
	logic [31:0] rd_data;
	logic [1:0] rd_resp, wr_resp;
	int n_fail = 0, comparisons = 0, cycles = 0;

	rss_top #(.TREC_LONG_CYC(TL), .TREC_HALT_CYC(TH), .BATT_CHECK_CYC({16'h0, BC}),
		.SERIAL_NUMBER(SER)) u_dut (.*);
	rss_pin_model u_pins (.i_power_fail_output_1(o_power_fail_output_1),
		.i_power_fail_output_1_oe(o_power_fail_output_1_oe), .i_power_fail_output_2(o_power_fail_output_2),
		.i_power_fail_output_2_oe(o_power_fail_output_2_oe), .i_irq(o_interrupt_level_pin),
		.i_irq_oe(o_interrupt_level_pin_oe), .o_power_fail_output_1_lvl(power_fail_output_1_lvl),
		.o_power_fail_output_2_lvl(power_fail_output_2_lvl), .o_irq_lvl_n(irq_lvl_n));

	always #10 i_clk = ~i_clk;

	task automatic conclude;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// whole run is under 12000 cycles
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			n_fail++;
			conclude;
		end
	end

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask

	task automatic chb(input string s, input logic e, input logic g);
		chk(s, {31'h0, e}, {31'h0, g});
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		@(posedge i_clk);
		i_axi_awaddr <= {idx, 2'b00};
		i_axi_wdata <= {24'h0, d};
		i_axi_awvalid <= 1'b1;
		i_axi_wvalid <= 1'b1;
		i_axi_bready <= 1'b1;
		forever
		begin
			@(posedge i_clk);
			if (o_axi_awready)
				i_axi_awvalid <= 1'b0;
			if (o_axi_wready)
				i_axi_wvalid <= 1'b0;
			if (o_axi_bvalid)
				break;
		end
		wr_resp = o_axi_bresp;
		i_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] idx);
		@(posedge i_clk);
		i_axi_araddr <= {idx, 2'b00};
		i_axi_arvalid <= 1'b1;
		i_axi_rready <= 1'b1;
		forever
		begin
			@(posedge i_clk);
			if (o_axi_arready)
				i_axi_arvalid <= 1'b0;
			if (o_axi_rvalid)
				break;
		end
		rd_data = o_axi_rdata;
		rd_resp = o_axi_rresp;
		i_axi_rready <= 1'b0;
	endtask

	task automatic rdc(input logic [5:0] i, input logic [7:0] m,
		input logic [7:0] e, input string s);
		rd(i);
		chk(s, {24'h0, e}, rd_data & {24'h0, m});
	endtask

	// counts edges until deselect is seen low; latency of sync included
	task automatic rec(input int t);
		int n;
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (o_deselect);
		chb("recovery length", 1'b1, n >= t && n <= t + 8);
	endtask

	task automatic pwr(input int t);
		@(posedge i_clk);
		i_vcc_ok <= 1'b0;
		wt(10);
		i_vcc_ok <= 1'b1;
		rec(t);
	endtask

	task automatic t_defaults;
		rdc(`RSS_IDX_CFG_A, 8'hff, `RSS_RST_CFG_A, "cfg a");
		rdc(`RSS_IDX_CFG_B, 8'hff, `RSS_RST_CFG_B, "cfg b");
		rdc(`RSS_IDX_WDOG, 8'hff, 8'h00, "watchdog");
		rdc(`RSS_IDX_FLAGS, 8'h04, 8'h04, "fail flag");
		rdc(`RSS_IDX_CONTROL, 8'h80, 8'h80, "out bit");
		rdc(`RSS_IDX_SECONDS, 8'h80, 8'h00, "halt bit");
		rdc(`RSS_IDX_HOURS, 8'h80, 8'h00, "length bit");
		chb("khz32 enable", 1'b1, o_khz32_output_enable);
		chb("square wave enable", 1'b0, o_square_wave_enable);
		chb("reset output", 1'b0, o_reset_output_pin_oe);
		wr(`RSS_IDX_SERIAL_LO, 8'h00);
		chk("write resp", {30'h0, `RSS_RESP_OKAY}, {30'h0, wr_resp});
		rd(`RSS_IDX_SERIAL_LO);
		chk("serial low", SER[31:0], rd_data);
		rd(`RSS_IDX_SERIAL_HI);
		chk("serial high", SER[63:32], rd_data);
		rd(6'h3f);
		chk("unmapped read", {30'h0, `RSS_RESP_SLVERR}, {30'h0, rd_resp});
		wr(6'h3f, 8'h00);
		chk("unmapped write", {30'h0, `RSS_RESP_SLVERR}, {30'h0, wr_resp});
	endtask

	task automatic t_pfo;
		chb("power_fail_output_1 open drain", 1'b0, o_power_fail_output_1_oe);
		chb("power_fail_output_1 level", 1'b1, power_fail_output_1_lvl);
		wr(`RSS_IDX_CFG_A, 8'hc0);
		i_pfi2_low <= 1'b1;
		wt(5);
		chb("power_fail_output_1 push-pull", 1'b1, o_power_fail_output_1_oe);
		chb("power_fail_output_2 level", 1'b0, power_fail_output_2_lvl);
		i_pfi2_low <= 1'b0;
		wr(`RSS_IDX_CFG_A, 8'he0);
	endtask

	task automatic t_osc;
		wr(`RSS_IDX_CFG_A, 8'he1);
		wt(4);
		rdc(`RSS_IDX_FLAGS, 8'h04, 8'h04, "fail flag");
		wt(2);
		chb("irq after flag read", 1'b0, irq_lvl_n);
		wr(`RSS_IDX_FLAGS, 8'h00);
		wt(4);
		chb("irq after clear", 1'b1, irq_lvl_n);
		i_osc_running <= 1'b0;
		wt(6);
		chb("irq on stop", 1'b0, irq_lvl_n);
		wr(`RSS_IDX_FLAGS, 8'h00);
		rdc(`RSS_IDX_FLAGS, 8'h04, 8'h04, "flag while stopped");
		i_osc_running <= 1'b1;
		wt(6);
		wr(`RSS_IDX_FLAGS, 8'h00);
		rdc(`RSS_IDX_FLAGS, 8'h04, 8'h00, "flag cleared");
		wr(`RSS_IDX_SECONDS, 8'h80);
		rdc(`RSS_IDX_FLAGS, 8'h04, 8'h04, "flag on halt");
		wr(`RSS_IDX_CFG_A, 8'he0);
		wt(4);
		chb("irq after enable off", 1'b1, irq_lvl_n);
	endtask

	task automatic t_recovery;
		pwr(TH);
		wr(`RSS_IDX_HOURS, 8'h80);
		rdc(`RSS_IDX_HOURS, 8'h80, 8'h80, "length bit");
		pwr(2500);
		wr(`RSS_IDX_HOURS, 8'h00);
		wr(`RSS_IDX_SECONDS, 8'h00);
		pwr(TL);
	endtask

	task automatic t_out_pin;
		wr(`RSS_IDX_CONTROL, 8'h00);
		wt(4);
		chb("pin follows out 0", 1'b0, irq_lvl_n);
		wr(`RSS_IDX_CONTROL, 8'h80);
		wt(4);
		chb("pin follows out 1", 1'b1, irq_lvl_n);
		wr(`RSS_IDX_CONTROL, 8'h00);
		wr(`RSS_IDX_CFG_A, 8'he4);
		i_vcc_ok <= 1'b0;
		wt(20);
		chb("fallback on backup", 1'b0, irq_lvl_n);
		chb("deselect on backup", 1'b1, o_deselect);
		chb("reset on backup", 1'b1, o_reset_output_pin_oe);
		i_vcc_ok <= 1'b1;
		rec(TL);
		rdc(`RSS_IDX_CFG_A, 8'hff, 8'he0, "backup enable");
		wr(`RSS_IDX_CONTROL, 8'h80);
	endtask

	task automatic t_century;
		for (int c = 0; c < 4; c++)
		begin
			wr(`RSS_IDX_CENTURY, 8'(c));
			wr(`RSS_IDX_YEAR, 8'h99);
			i_year_advance <= 1'b1;
			@(posedge i_clk);
			i_year_advance <= 1'b0;
			wt(3);
			rdc(`RSS_IDX_CENTURY, 8'h03, 8'((c + 1) % 4), "century");
			rdc(`RSS_IDX_YEAR, 8'hff, 8'h00, "year");
			rdc(`RSS_IDX_DATE, 8'h01, {7'h0, c == 3}, "leap bit");
			chb("leap output", c == 3, o_leap_year);
		end
	endtask

	task automatic t_battery;
		i_battery_low <= 1'b1;
		pwr(TL);
		i_battery_low <= 1'b0;
		rdc(`RSS_IDX_FLAGS, 8'h10, 8'h10, "low at power-up");
		rdc(`RSS_IDX_FLAGS, 8'h10, 8'h10, "low held");
		wt(BC + 20);
		rdc(`RSS_IDX_FLAGS, 8'h10, 8'h00, "low after daily");
		i_vcc_ok <= 1'b0;
		wt(5);
		i_battery_low <= 1'b1;
		wt(BC + 20);
		rdc(`RSS_IDX_FLAGS, 8'h10, 8'h00, "low on backup");
		i_battery_low <= 1'b0;
		wt(5);
		i_vcc_ok <= 1'b1;
		rec(TL);
	endtask

	task automatic t_supply;
		wr(`RSS_IDX_CFG_A, 8'hff);
		wr(`RSS_IDX_CFG_B, 8'h1f);
		wr(`RSS_IDX_WDOG, 8'h05);
		pwr(TL);
		rdc(`RSS_IDX_CFG_A, 8'hff, 8'he0, "cfg a");
		rdc(`RSS_IDX_CFG_B, 8'hff, 8'h07, "cfg b");
		rdc(`RSS_IDX_WDOG, 8'hff, 8'h00, "watchdog");
	endtask

	initial
	begin
		wt(10);
		i_reset_n <= 1'b1;
		rec(TL);
		t_defaults;
		t_pfo;
		t_osc;
		t_recovery;
		t_out_pin;
		t_century;
		t_battery;
		t_supply;
		conclude;
	end
endmodule

bind rss_top rss_sva #(.TREC_LONG_CYC(TREC_LONG_CYC),
	.TREC_HALT_CYC(TREC_HALT_CYC)) u_sva (.*);
`default_nettype wire
